// File: shared/urx_pkg.sv
package urx_pkg;
  // Oversampling: sixteen samples per bit.
  localparam int URX_OVS = 16;
  localparam logic [3:0] URX_OVS_LAST = 4'hf;
  localparam logic [3:0] URX_MID_SAMPLE = 4'h7;
  localparam logic [3:0] URX_VOTE_FIRST = 4'h6;
  localparam logic [3:0] URX_VOTE_LAST = 4'h8;
  // Bits after the start bit: 8 or 9 data bits.
  localparam logic [3:0] URX_BITS_EIGHT = 4'h8;
  localparam logic [3:0] URX_BITS_NINE = 4'h9;
  // Receive buffer depth and entry layout {parity_err, frame_err, bit8, data[7:0]}.
  localparam int URX_DEPTH = 2;
  localparam int URX_ENTRY_W = 11;
  localparam int URX_POS_BIT8 = 8;
  localparam int URX_POS_FERR = 9;
  localparam int URX_POS_PERR = 10;
  localparam logic [URX_ENTRY_W-1:0] URX_ENTRY_RST = 11'h000;
  localparam logic [7:0] URX_DATA_RST = 8'h00;
  // Parity type select: 0 even, 1 odd.
  localparam logic URX_PAR_ODD = 1'b1;
  typedef enum logic [4:0] {
    URX_IDLE = 5'h01,
    URX_START = 5'h02,
    URX_DATA = 5'h04,
    URX_STOP = 5'h08,
    URX_WAIT_HIGH = 5'h10
  } urx_state_t;
endpackage

// File: src/urx_buf.sv
`timescale 1ns/1ps
// Two-entry receive buffer; read data comes out of a register.
module urx_buf
  import urx_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic [URX_ENTRY_W-1:0] wr_data,
  input wire logic rd_en,
  output logic [URX_ENTRY_W-1:0] rd_data,
  output logic [1:0] count
);
  logic [URX_ENTRY_W-1:0] mem [URX_DEPTH];
  logic rd_ptr;
  logic wr_ptr;
  logic do_wr;
  logic do_rd;

  assign do_rd = rd_en && (count != 2'h0);
  assign do_wr = wr_en && ((count != 2'h2) || do_rd);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mem[0] <= URX_ENTRY_RST;
      mem[1] <= URX_ENTRY_RST;
    end else if (do_wr) begin
      mem[wr_ptr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (do_wr) wr_ptr <= ~wr_ptr;
      if (do_rd) rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, do_wr} - {1'b0, do_rd};
    end
  end

  // Head register: shows the oldest entry, or a write landing in an empty buffer.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rd_data <= URX_ENTRY_RST;
    end else if (do_rd && (count == 2'h2)) begin
      rd_data <= mem[~rd_ptr];
    end else if (do_wr && ((count == 2'h0) || (do_rd && (count == 2'h1)))) begin
      rd_data <= wr_data;
    end
  end
endmodule // urx_buf

// File: src/urx_receiver.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module urx_receiver
  import urx_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic baud16_tick,
  input wire logic rx_enable,
  input wire logic rx_pin,
  input wire logic nine_bit_select,
  input wire logic parity_enable,
  input wire logic parity_odd,
  input wire logic stop_count_select,
  input wire logic addr_detect_enable,
  input wire logic rx_int_enable,
  input wire logic rx_wake_enable,
  input wire logic tx_empty_int_enable,
  input wire logic tx_idle_int_enable,
  input wire logic tx_empty_flag,
  input wire logic tx_idle_flag,
  input wire logic low_power_idle_mode,
  input wire logic status_access,
  input wire logic data_read,
  output logic [7:0] rx_data_buffer,
  output logic rx_ninth_bit,
  output logic rx_avail_flag,
  output logic overrun_flag,
  output logic noise_flag,
  output logic frame_err_flag,
  output logic parity_err_flag,
  output logic rx_idle_flag,
  output logic wake_req,
  output logic int_req_n
);

  function automatic logic vote3(input logic [2:0] s);
    vote3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  // The available and error flags and the pop all ask whether the buffer holds a character.
  function automatic logic has_data(input logic [1:0] n);
    has_data = (n != 2'h0);
  endfunction

  urx_state_t state;
  logic [3:0] ovs_cnt;
  logic [3:0] bit_cnt;
  logic [2:0] samples;
  logic [8:0] rx_shift_reg;
  logic parity_acc;
  logic noisy;
  logic stop_bad;
  logic second_stop;
  logic pin_prev;
  logic status_seen;
  logic tx_empty_prev;
  logic tx_idle_prev;
  logic [1:0] buf_count;
  logic [URX_ENTRY_W-1:0] head;
  logic frame_done;
  logic push;
  logic pop;
  logic [URX_ENTRY_W-1:0] push_entry;
  logic last_sample;
  logic bit_level;
  logic bit_noisy;
  logic [3:0] data_bits;
  logic frame_par_err;
  logic frame_fe;
  logic is_break;
  logic addr_bit;
  logic int_event;

  assign data_bits = nine_bit_select ? URX_BITS_NINE : URX_BITS_EIGHT;
  assign last_sample = baud16_tick && (ovs_cnt == URX_OVS_LAST);
  // Each bit is decided by a majority over three samples near the centre.
  assign bit_level = vote3(samples);
  assign bit_noisy = (samples != 3'h0) && (samples != 3'h7);

  ////////////////////////////////////////////////////////////////////////////////
  // Frame sequencer.

  // Previous pin level for the wake-up edge; it resets to the idle high level
  // so a line that is already low when reset ends reads as a falling edge.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pin_prev <= 1'b1;
    end else begin
      pin_prev <= rx_pin;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= URX_IDLE;
      ovs_cnt <= 4'h0;
      bit_cnt <= 4'h0;
      samples <= 3'h0;
      rx_shift_reg <= 9'h000;
      parity_acc <= 1'b0;
      noisy <= 1'b0;
      stop_bad <= 1'b0;
      second_stop <= 1'b0;
    end else if (!rx_enable) begin
      state <= URX_IDLE;
    end else begin
      // The oversample counter runs free between frames; a start edge reloads it
      // so that the three votes fall near the centre of every bit.
      if (baud16_tick) begin
        ovs_cnt <= ovs_cnt + 4'h1;
        if ((ovs_cnt >= URX_VOTE_FIRST) && (ovs_cnt <= URX_VOTE_LAST)) begin
          samples <= {samples[1:0], rx_pin};
        end
      end
      case (state)
        URX_IDLE: begin
          if (baud16_tick && !rx_pin) begin
            state <= URX_START;
            ovs_cnt <= 4'h1;
            noisy <= 1'b0;
            stop_bad <= 1'b0;
            parity_acc <= 1'b0;
            bit_cnt <= 4'h0;
          end
        end
        URX_START: begin
          if (last_sample) begin
            // A start bit that votes high was a glitch; go back to searching.
            state <= bit_level ? URX_IDLE : URX_DATA;
          end
        end
        URX_DATA: begin
          if (last_sample) begin
            // LSB first, so each bit enters at the top and shifts down.
            if (nine_bit_select) begin
              rx_shift_reg <= {bit_level, rx_shift_reg[8:1]};
            end else begin
              rx_shift_reg <= {1'b0, bit_level, rx_shift_reg[7:1]};
            end
            parity_acc <= parity_acc ^ bit_level;
            noisy <= noisy | bit_noisy;
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == data_bits - 4'h1) begin
              state <= URX_STOP;
              second_stop <= 1'b0;
            end
          end
        end
        URX_STOP: begin
          if (last_sample) begin
            noisy <= noisy | bit_noisy;
            if (stop_count_select && !second_stop) begin
              // Both stop bits must be high when two are selected.
              stop_bad <= !bit_level;
              second_stop <= 1'b1;
            end else if (stop_bad || !bit_level) begin
              // A low stop level may be a break; never mistake it for a start.
              state <= URX_WAIT_HIGH;
            end else begin
              state <= URX_IDLE;
            end
          end
        end
        URX_WAIT_HIGH: begin
          if (rx_pin) begin
            state <= URX_IDLE;
          end
        end
        default: begin
          state <= URX_IDLE;
        end
      endcase
    end
  end

  // The frame ends on the last stop sample; with two stops only after the second.
  assign frame_done = rx_enable && (state == URX_STOP) && last_sample &&
                      (!stop_count_select || second_stop);
  // The break ends after the configured bit count however long the line stays low.
  assign frame_fe = stop_bad || !bit_level;
  assign is_break = frame_fe && (rx_shift_reg == 9'h000);
  // Parity is the last counted data bit, so even parity leaves the running sum at zero.
  assign frame_par_err = parity_enable &&
                         (parity_acc != (parity_odd == URX_PAR_ODD));

  ////////////////////////////////////////////////////////////////////////////////
  // Buffer and flags.

  // A break carries no data: the word is forced to zero while the error bits stay.
  always_comb begin
    push_entry = {frame_par_err, frame_fe, rx_shift_reg};
    if (is_break) begin
      push_entry[URX_POS_BIT8:0] = 9'h000;
    end
  end

  // Overrun: buffer full and no read in this cycle drops the new frame.
  assign push = frame_done;
  assign pop = data_read && status_seen && has_data(buf_count);

  urx_buf u_buf (
    .clk_sys(clk_sys),
    .srst(srst),
    .wr_en(push),
    .wr_data(push_entry),
    .rd_en(pop),
    .rd_data(head),
    .count(buf_count)
  );

  assign rx_data_buffer = head[7:0];
  assign rx_ninth_bit = head[URX_POS_BIT8];
  // The error bits travel with the head character, so they change when it is popped.
  assign frame_err_flag = has_data(buf_count) && head[URX_POS_FERR];
  assign parity_err_flag = has_data(buf_count) && head[URX_POS_PERR];
  assign rx_avail_flag = has_data(buf_count);

  // A status access arms the clearing read; read-only flags clear otherwise only on reset.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      status_seen <= 1'b0;
    end else if (status_access) begin
      status_seen <= 1'b1;
    end else if (data_read) begin
      status_seen <= 1'b0;
    end
  end

  // Set wins over the clearing sequence in the same cycle.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      overrun_flag <= 1'b0;
    end else if (push && (buf_count == 2'h2) && !pop) begin
      overrun_flag <= 1'b1;
    end else if (data_read && status_seen) begin
      overrun_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      noise_flag <= 1'b0;
    end else if (push && noisy) begin
      noise_flag <= 1'b1;
    end else if (data_read && status_seen) begin
      noise_flag <= 1'b0;
    end
  end

  // A false start or a disabled receiver returns to searching, which counts as idle.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rx_idle_flag <= 1'b1;
    end else if (frame_done || !rx_enable) begin
      rx_idle_flag <= 1'b1;
    end else if ((state == URX_START) && last_sample && bit_level) begin
      rx_idle_flag <= 1'b1;
    end else if (state == URX_START) begin
      rx_idle_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt request.

  assign addr_bit = nine_bit_select ? push_entry[8] : push_entry[7];

  // All sources merge into one event; events that meet in one cycle share
  // a single pulse; the flags let software tell them apart, except wake-up, which has none.

  always_comb begin
    int_event = 1'b0;
    if (rx_int_enable && push) begin
      // Address detect qualifies only the data-available source.
      if (!addr_detect_enable || addr_bit) begin
        int_event = 1'b1;
      end
      if (buf_count == 2'h2 && !pop) begin
        int_event = 1'b1;
      end
    end
    // Transmit sources raise a pulse on their rising edge, each by its own enable.
    if (tx_empty_int_enable && tx_empty_flag && !tx_empty_prev) begin
      int_event = 1'b1;
    end
    if (tx_idle_int_enable && tx_idle_flag && !tx_idle_prev) begin
      int_event = 1'b1;
    end
    if (wake_req && rx_int_enable) begin
      int_event = 1'b1;
    end
  end

  // The previous levels reset high: a transmit flag already set when reset
  // ends must not look like a fresh rising edge and raise a stray request.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tx_empty_prev <= 1'b1;
      tx_idle_prev <= 1'b1;
    end else begin
      tx_empty_prev <= tx_empty_flag;
      tx_idle_prev <= tx_idle_flag;
    end
  end

  // Wake-up has no flag; it is a one-cycle request on a falling pin edge.
  // The edge is seen only while the system clock runs; a stopped clock needs a detector elsewhere.
  assign wake_req = low_power_idle_mode && rx_wake_enable && rx_int_enable &&
                    pin_prev && !rx_pin;

  // Registered so the low pulse is exactly one clean cycle per event.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      int_req_n <= 1'b1;
    end else begin
      int_req_n <= !int_event;
    end
  end
endmodule // urx_receiver

// File: tb/urx_checker.sv
`timescale 1ns/1ps
// Port watcher for the receiver; one clock domain, so defaults are set once.
module urx_checker (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic rx_int_enable,
  input wire logic addr_detect_enable,
  input wire logic tx_empty_int_enable,
  input wire logic tx_idle_int_enable,
  input wire logic data_read,
  input wire logic rx_avail_flag,
  input wire logic overrun_flag,
  input wire logic noise_flag,
  input wire logic frame_err_flag,
  input wire logic parity_err_flag,
  input wire logic rx_idle_flag,
  input wire logic int_req_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_push; $rose(rx_avail_flag); endsequence
  sequence s_quiet; (!rx_int_enable && !tx_empty_int_enable && !tx_idle_int_enable) [*2]; endsequence
  property p_pulse; $fell(int_req_n) |=> int_req_n; endproperty
  property p_push_int; (rx_int_enable && !addr_detect_enable) ##0 s_push |-> !int_req_n; endproperty
  property p_quiet; s_quiet |-> int_req_n; endproperty
  property p_err_gate; frame_err_flag || parity_err_flag |-> rx_avail_flag; endproperty
  property p_avail_hold; rx_avail_flag && !data_read |=> rx_avail_flag; endproperty
  property p_ovr_hold; overrun_flag && !data_read |=> overrun_flag; endproperty
  property p_noise_hold; noise_flag && !data_read |=> noise_flag; endproperty
  property p_noise_set; $rose(noise_flag) |-> rx_avail_flag; endproperty
  property p_ovr_int; rx_int_enable && $rose(overrun_flag) |-> ##[0:1] !int_req_n; endproperty
  property p_idle_push; s_push |-> ##[0:1] rx_idle_flag; endproperty
  a_pulse: assert property (p_pulse) else $error("long pulse");
  a_push_int: assert property (p_push_int) else $error("no push irq");
  a_quiet: assert property (p_quiet) else $error("masked irq");
  a_err_gate: assert property (p_err_gate) else $error("stray error flag");
  a_avail_hold: assert property (p_avail_hold) else $error("avail lost");
  a_ovr_hold: assert property (p_ovr_hold) else $error("overrun lost");
  a_noise_hold: assert property (p_noise_hold) else $error("noise lost");
  a_noise_set: assert property (p_noise_set) else $error("noise alone");
  a_ovr_int: assert property (p_ovr_int) else $error("no overrun irq");
  a_idle_push: assert property (p_idle_push) else $error("not idle");
endmodule // urx_checker

// File: tb/urx_remote_tx.sv
`timescale 1ns/1ps
// Far-end transmitter; the line rests high between frames.
module urx_remote_tx #(
  parameter int BIT_CYC = 32
) (
  input wire logic clk_sys,
  output logic rx_pin
);
  initial rx_pin = 1'b1;
  // Start, nb bits LSB first, two stops; g flips one mid sample of bit 0 as noise.
  task automatic send(input logic [19:0] w, input int nb, input logic [1:0] stp, input bit g);
    logic b;
    for (int i = 0; i <= nb + 2; i++) begin
      b = (i == 0) ? 1'b0 : (i <= nb) ? w[i-1] : stp[i-nb-1];
      for (int c = 0; c < BIT_CYC; c++) begin
        @(negedge clk_sys);
        rx_pin = b ^ (g && i == 1 && c / 2 == 7);
      end
    end
    @(negedge clk_sys);
    rx_pin = 1'b1;
  endtask
endmodule // urx_remote_tx

// File: tb/test_urx_receiver.sv
`timescale 1ns/1ps
module test_urx_receiver;
  logic clk_sys = 1'b0, srst = 1'b1, tick = 1'b0, nine = 1'b0, par_en = 1'b0, podd = 1'b0;
  logic two = 1'b0, addr_en = 1'b0, rie = 1'b0, te = 1'b0, txf = 1'b0, sa = 1'b0, dr = 1'b0;
  logic wk = 1'b0, lp = 1'b0;
  logic rx_pin, ninth, av, ovr, nf, fe, pe, idle, irq_n, wake;
  logic [7:0] dout;
  int n_errors = 0, tests_run = 0, n_int = 0, n_wake = 0;
  initial forever #25 clk_sys = ~clk_sys;
  // A tick every other cycle keeps a bit at 32 cycles and the run short.
  always @(negedge clk_sys) tick <= ~tick;
  always @(posedge clk_sys) if (irq_n === 1'b0) n_int <= n_int + 1;
  always @(posedge clk_sys) if (wake === 1'b1) n_wake <= n_wake + 1;
  urx_remote_tx i_urx_remote_tx (.clk_sys(clk_sys), .rx_pin(rx_pin));
  urx_receiver i_urx_receiver (.clk_sys(clk_sys), .srst(srst), .baud16_tick(tick),
    .rx_enable(1'b1), .rx_pin(rx_pin), .nine_bit_select(nine), .parity_enable(par_en),
    .parity_odd(podd), .stop_count_select(two), .addr_detect_enable(addr_en),
    .rx_int_enable(rie), .rx_wake_enable(wk), .tx_empty_int_enable(te),
    .tx_idle_int_enable(1'b0), .tx_empty_flag(txf), .tx_idle_flag(txf),
    .low_power_idle_mode(lp), .status_access(sa), .data_read(dr), .rx_data_buffer(dout),
    .rx_ninth_bit(ninth), .rx_avail_flag(av), .overrun_flag(ovr), .noise_flag(nf),
    .frame_err_flag(fe), .parity_err_flag(pe), .rx_idle_flag(idle), .wake_req(wake),
    .int_req_n(irq_n));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic tx(input logic [19:0] w, input int nb, input logic [1:0] s = 2'b11,
                    input bit g = 1'b0);
    i_urx_remote_tx.send(w, nb, s, g);
  endtask
  // Flags are checked after the status access and before the pop, as they follow the word.
  task automatic rd(input logic [8:0] exp, input logic [1:0] err);
    @(negedge clk_sys);
    sa = 1'b1;
    @(negedge clk_sys);
    sa = 1'b0;
    chk(9'({pe, fe}), 9'(err));
    chk({nine & ninth, dout}, exp);
    dr = 1'b1;
    @(negedge clk_sys);
    dr = 1'b0;
  endtask
  task automatic s_basic();
    int k = n_int;
    fork
      tx(20'h0005a, 8);
      begin
        repeat (100) @(negedge clk_sys);
        chk(9'(idle), 9'h000);
      end
    join
    chk(9'({av, idle}), 9'h003);
    chk(9'(n_int - k), 9'h001);
    rd(9'h05a, 2'b00);
    chk(9'(av), 9'h000);
  endtask
  task automatic s_overrun();
    int k = n_int;
    tx(20'h11, 8);
    tx(20'h22, 8);
    tx(20'h33, 8);
    chk(9'(ovr), 9'h001);
    chk(9'(n_int - k), 9'h003);
    @(negedge clk_sys);
    dr = 1'b1;
    @(negedge clk_sys);
    dr = 1'b0;
    chk(9'({av, ovr}), 9'h003);
    rd(9'h011, 2'b00);
    chk(9'(ovr), 9'h000);
    rd(9'h022, 2'b00);
    chk(9'(av), 9'h000);
  endtask
  task automatic s_break();
    int k = n_int;
    tx(20'h0, 20);
    chk(9'({av, idle}), 9'h003);
    chk(9'(n_int - k), 9'h001);
    rd(9'h000, 2'b01);
    tx(20'h0c3, 8);
    rd(9'h0c3, 2'b00);
    chk(9'(av), 9'h000);
    two = 1'b1;
    tx(20'h081, 8, 2'b01);
    rd(9'h081, 2'b01);
    tx(20'h042, 8);
    rd(9'h042, 2'b00);
    two = 1'b0;
  endtask
  task automatic s_parity();
    nine = 1'b1;
    par_en = 1'b1;
    for (int m = 0; m < 4; m++) begin
      podd = m[1];
      tx({11'h000, m[1] ^ m[0], 8'h03}, 9);
      rd({m[1] ^ m[0], 8'h03}, {m[0], 1'b0});
    end
    // Odd parity is still selected, so this word would fail if checking stayed on.
    par_en = 1'b0;
    tx(20'h003, 9);
    rd(9'h003, 2'b00);
  endtask
  task automatic s_addr();
    int k;
    logic [19:0] w;
    addr_en = 1'b1;
    par_en = 1'b0;
    for (int m = 0; m < 4; m++) begin
      nine = m[1];
      w = 20'h012 | (20'(m[0]) << (m[1] ? 8 : 7));
      k = n_int;
      tx(w, m[1] ? 9 : 8);
      chk(9'(n_int - k), 9'(m[0]));
      rd(w[8:0], 2'b00);
    end
    addr_en = 1'b0;
    nine = 1'b0;
  endtask
  task automatic s_noise_mask();
    int k = n_int;
    tx(20'h0f0, 8, 2'b11, 1'b1);
    chk(9'(nf), 9'h001);
    chk(9'(n_int - k), 9'h001);
    rd(9'h0f0, 2'b00);
    chk(9'(nf), 9'h000);
    rie = 1'b0;
    te = 1'b1;
    k = n_int;
    tx(20'h055, 8);
    txf = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk(9'(n_int - k), 9'h001);
    rd(9'h055, 2'b00);
  endtask
  // Only the start bit of an all-ones word falls, so one wake request is expected.
  task automatic s_wake();
    int k = n_int;
    int kw = n_wake;
    chk(9'(kw), 9'h000);
    rie = 1'b1;
    wk = 1'b1;
    lp = 1'b1;
    tx(20'h0ff, 8);
    chk(9'(n_wake - kw), 9'h001);
    chk(9'(n_int - k), 9'h002);
    wk = 1'b0;
    lp = 1'b0;
    rd(9'h0ff, 2'b00);
  endtask
  // A reset in mid-run clears the buffered error and must not raise a stray request.
  task automatic s_reset();
    int k;
    tx(20'h0, 20);
    chk(9'({av, fe}), 9'h003);
    srst = 1'b1;
    repeat (2) @(negedge clk_sys);
    srst = 1'b0;
    k = n_int;
    repeat (3) @(negedge clk_sys);
    chk(9'({av, ovr, nf, fe, pe, idle, irq_n}), 9'h003);
    chk(9'(n_int - k), 9'h000);
  endtask
  initial begin
    repeat (5) @(negedge clk_sys);
    srst = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk(9'({av, ovr, nf, fe, pe, idle, irq_n}), 9'h003);
    rie = 1'b1;
    s_basic();
    s_overrun();
    s_break();
    s_parity();
    s_addr();
    s_noise_mask();
    s_wake();
    s_reset();
    complete_run();
  end
  initial begin
    #3000000;
    n_errors++;
    complete_run();
  end
endmodule // test_urx_receiver
bind urx_receiver urx_checker i_urx_checker (.clk_sys(clk_sys), .srst(srst),
  .rx_int_enable(rx_int_enable), .addr_detect_enable(addr_detect_enable),
  .tx_empty_int_enable(tx_empty_int_enable), .tx_idle_int_enable(tx_idle_int_enable),
  .data_read(data_read), .rx_avail_flag(rx_avail_flag), .overrun_flag(overrun_flag),
  .noise_flag(noise_flag), .frame_err_flag(frame_err_flag), .parity_err_flag(parity_err_flag),
  .rx_idle_flag(rx_idle_flag), .int_req_n(int_req_n));
